// [hdl/fbmc_defs.vh]
`ifndef FBMC_DEFS_VH
`define FBMC_DEFS_VH
// Command codes
`define FBMC_CMD_READ_ARRAY 8'hff
`define FBMC_CMD_READ_ID 8'h90
`define FBMC_CMD_READ_STATUS 8'h70
`define FBMC_CMD_CLEAR_STATUS 8'h50
`define FBMC_CMD_ERASE_SETUP 8'h20
`define FBMC_CMD_CONFIRM 8'hd0
`define FBMC_CMD_WRITE_SETUP 8'h40
`define FBMC_CMD_LOCK_SETUP 8'h60
`define FBMC_CMD_SET_BLOCK_LOCK 8'h01
`define FBMC_CMD_SET_MASTER_LOCK 8'hf1
// Host request opcodes
`define FBMC_OP_READ 3'h0
`define FBMC_OP_CMD 3'h1
`define FBMC_OP_ERASE 3'h2
`define FBMC_OP_BYTE_WRITE 3'h3
`define FBMC_OP_BLOCK_LOCK 3'h4
`define FBMC_OP_MASTER_LOCK 3'h5
`define FBMC_OP_CLEAR_LOCKS 3'h6
`define FBMC_OP_RESET 3'h7
// Memory map
`define FBMC_ADDR_W 20
`define FBMC_BLOCK_MASK 20'hf0000
// Timing, in ns and derived cycles at 100 MHz
`define FBMC_CLK_NS 10
`define FBMC_PD_LOW_NS 100
`define FBMC_PD_LOW_CYC ((`FBMC_PD_LOW_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_WAKE_NS 1000
`define FBMC_WAKE_CYC ((`FBMC_WAKE_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_STROBE_NS 100
`define FBMC_STROBE_CYC ((`FBMC_STROBE_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_CNT_W 8
`endif

// [hdl/fbmc_host.v]
`timescale 1ns/10ps
`default_nettype none
`include "fbmc_defs.vh"
module fbmc_host (
  input wire ref_clk,
  input wire rst,
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [19:0] req_addr,
  input wire [7:0] req_data,
  output reg req_ready,
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg busy,
  output reg [19:0] addr_out,
  output reg chip_select_n,
  output reg output_gate_n,
  output reg write_strobe_n,
  output reg powerdown_reset_n,
  output reg [7:0] data_out,
  output reg data_oe_n,
  input wire [7:0] data_in,
  input wire ready_busy_n
);
  localparam ST_WAKE = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_RD = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_GAP = 3'h4;
  localparam ST_POLL = 3'h5;
  localparam ST_PD = 3'h6;

  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg second_q;
  reg [2:0] op_q;
  reg [7:0] data2_q;
  reg [2:0] rb_sync_q;
  reg rb_q;
  reg [7:0] din_q;
  reg [7:0] din2_q;
  reg [7:0] din3_q;
  reg [7:0] din_hold_q;

  // Block base of an address, for block-addressed commands
  function [19:0] blk_base;
    input [19:0] a;
    begin
      blk_base = a & `FBMC_BLOCK_MASK;
    end
  endfunction

  // Three-stage sync of the busy pin, change accepted when the last two stages agree
  always @(posedge ref_clk) begin
    if (rst) begin
      rb_sync_q <= 3'h7;
      rb_q <= 1'b1;
    end else begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_n};
      if (rb_sync_q[1] == rb_sync_q[2])
        rb_q <= rb_sync_q[2];
    end
  end

  // Data lines through three stages, kept once the last two agree
  always @(posedge ref_clk) begin
    if (rst) begin
      din_q <= 8'h00;
      din2_q <= 8'h00;
      din3_q <= 8'h00;
      din_hold_q <= 8'h00;
    end else begin
      din_q <= data_in;
      din2_q <= din_q;
      din3_q <= din2_q;
      if (din2_q == din3_q)
        din_hold_q <= din3_q;
    end
  end

  // Bus sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_PD;
      cnt_q <= 8'h00;
      second_q <= 1'b0;
      op_q <= 3'h0;
      data2_q <= 8'h00;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      busy <= 1'b1;
      addr_out <= 20'h00000;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      powerdown_reset_n <= 1'b0;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_PD: begin
          // Hold reset low at least the minimum time
          if (cnt_q >= `FBMC_PD_LOW_CYC - 1) begin
            powerdown_reset_n <= 1'b1;
            cnt_q <= 8'h00;
            state_q <= ST_WAKE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_WAKE: begin
          // No write before the wake interval
          if (cnt_q >= `FBMC_WAKE_CYC - 1) begin
            cnt_q <= 8'h00;
            busy <= 1'b0;
            req_ready <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_IDLE: begin
          if (req_valid) begin
            req_ready <= 1'b0;
            busy <= 1'b1;
            op_q <= req_op;
            cnt_q <= 8'h00;
            second_q <= 1'b0;
            chip_select_n <= 1'b0;
            case (req_op)
              `FBMC_OP_READ: begin
                addr_out <= req_addr;
                output_gate_n <= 1'b0;
                state_q <= ST_RD;
              end
              `FBMC_OP_CMD: begin
                addr_out <= req_addr;
                data_out <= req_data;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              `FBMC_OP_ERASE: begin
                addr_out <= blk_base(req_addr);
                data_out <= `FBMC_CMD_ERASE_SETUP;
                data2_q <= `FBMC_CMD_CONFIRM;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              `FBMC_OP_BYTE_WRITE: begin
                addr_out <= req_addr;
                data_out <= `FBMC_CMD_WRITE_SETUP;
                data2_q <= req_data;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              `FBMC_OP_BLOCK_LOCK: begin
                addr_out <= blk_base(req_addr);
                data_out <= `FBMC_CMD_LOCK_SETUP;
                data2_q <= `FBMC_CMD_SET_BLOCK_LOCK;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              `FBMC_OP_MASTER_LOCK: begin
                addr_out <= req_addr;
                data_out <= `FBMC_CMD_LOCK_SETUP;
                data2_q <= `FBMC_CMD_SET_MASTER_LOCK;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              `FBMC_OP_CLEAR_LOCKS: begin
                addr_out <= req_addr;
                data_out <= `FBMC_CMD_LOCK_SETUP;
                data2_q <= `FBMC_CMD_CONFIRM;
                data_oe_n <= 1'b0;
                write_strobe_n <= 1'b0;
                state_q <= ST_WR;
              end
              default: begin
                // Device reset through power-down
                chip_select_n <= 1'b1;
                powerdown_reset_n <= 1'b0;
                state_q <= ST_PD;
              end
            endcase
          end
        end
        ST_RD: begin
          // Wait access time, then sample data
          if (cnt_q >= `FBMC_STROBE_CYC + 1) begin
            rsp_data <= din_hold_q;
            rsp_valid <= 1'b1;
            output_gate_n <= 1'b1;
            chip_select_n <= 1'b1;
            busy <= 1'b0;
            req_ready <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_WR: begin
          // Strobe rises first; data held one more cycle
          if (cnt_q >= `FBMC_STROBE_CYC - 1) begin
            write_strobe_n <= 1'b1;
            cnt_q <= 8'h00;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_GAP: begin
          chip_select_n <= 1'b1;
          data_oe_n <= 1'b1;
          if (op_q != `FBMC_OP_CMD && !second_q) begin
            // Second cycle of the two-cycle sequence
            second_q <= 1'b1;
            chip_select_n <= 1'b0;
            data_out <= data2_q;
            data_oe_n <= 1'b0;
            write_strobe_n <= 1'b0;
            state_q <= ST_WR;
          end else if (op_q != `FBMC_OP_CMD) begin
            cnt_q <= 8'h00;
            state_q <= ST_POLL;
          end else begin
            busy <= 1'b0;
            req_ready <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_POLL: begin
          // Allow busy to assert, then wait for ready
          if (cnt_q < `FBMC_STROBE_CYC) begin
            cnt_q <= cnt_q + 8'h01;
          end else if (rb_q) begin
            addr_out <= 20'h00000;
            data_out <= `FBMC_CMD_READ_ARRAY;
            op_q <= `FBMC_OP_CMD;
            second_q <= 1'b1;
            chip_select_n <= 1'b0;
            data_oe_n <= 1'b0;
            write_strobe_n <= 1'b0;
            cnt_q <= 8'h00;
            state_q <= ST_WR;
          end
        end
        default: begin
          state_q <= ST_PD;
        end
      endcase
    end
  end
endmodule // fbmc_host
`default_nettype wire

// [testbench/fbmc_props.sv]
`timescale 1ns/10ps
`default_nettype none
module fbmc_props (
  input wire ref_clk,
  input wire rst,
  input wire req_ready,
  input wire rsp_valid,
  input wire busy,
  input wire [19:0] addr_out,
  input wire chip_select_n,
  input wire output_gate_n,
  input wire write_strobe_n,
  input wire powerdown_reset_n,
  input wire [7:0] data_out,
  input wire data_oe_n,
  input wire ready_busy_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Flash pin sequencing seen from the host side
  a_read_no_strobe: assert property (!output_gate_n |-> write_strobe_n) else $error("gate with strobe");
  a_write_drives: assert property (!write_strobe_n |-> !chip_select_n && !data_oe_n && output_gate_n)
    else $error("bad write cycle");
  a_host_release: assert property (!data_oe_n |-> output_gate_n) else $error("bus fight");
  a_pd_hold: assert property ($fell(powerdown_reset_n) |=> !powerdown_reset_n [*8]) else $error("short reset");
  a_pd_quiet: assert property (!powerdown_reset_n |-> chip_select_n && write_strobe_n)
    else $error("access in reset");
  a_wake_wait: assert property ($rose(powerdown_reset_n) |-> write_strobe_n [*8]) else $error("early write");
  a_read_answer: assert property ($fell(output_gate_n) |-> ##[1:20] rsp_valid) else $error("no read answer");
  a_two_cycle: assert property ($fell(write_strobe_n) && data_out == 8'h20 |->
    ##[2:40] ($fell(write_strobe_n) && data_out == 8'hd0)) else $error("no confirm");
  a_latch_stable: assert property ($rose(write_strobe_n) |-> $stable(addr_out) && $stable(data_out))
    else $error("moved at latch");
  a_busy_wait: assert property (!ready_busy_n [*4] |-> !req_ready) else $error("ready while busy");
  a_busy_flag: assert property (busy == !req_ready) else $error("busy flag mismatch");
endmodule // fbmc_props
bind fbmc_host fbmc_props u_props (.ref_clk, .rst, .req_ready, .rsp_valid, .busy, .addr_out, .chip_select_n,
  .output_gate_n, .write_strobe_n, .powerdown_reset_n, .data_out, .data_oe_n, .ready_busy_n);
`default_nettype wire

// [testbench/fbmc_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fbmc_flash_model #(
  parameter [7:0] MAKER = 8'h3c, // Arbitrary value
  parameter [7:0] PART = 8'hc3, // Arbitrary value
  parameter BUSY_NS = 400,
  parameter bit SUPPLY_OK = 1'b1, // Program supply above lockout
  parameter bit HIGH_RESET = 1'b0 // Reset pin at high voltage
) (
  input wire logic [19:0] addr_out,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic powerdown_reset_n,
  input wire logic [7:0] data_out,
  output wire logic [7:0] data_in,
  output var logic ready_busy_n
);
  logic [7:0] mem [logic [19:0]];
  logic [15:0] erased = 16'h0;
  logic [15:0] locked = 16'h0;
  logic [7:0] pend = 8'h0;
  logic [7:0] last = 8'h0;
  logic [7:0] rd = 8'h0;
  logic [1:0] mode = 2'd0;
  initial ready_busy_n = 1'b1;
  // Read source picked as the gate opens
  always @(negedge output_gate_n) begin
    if (mode == 2'd1) rd = 8'h80;
    else if (mode == 2'd2) rd = addr_out[0] ? PART : MAKER;
    else if (mem.exists(addr_out)) rd = mem[addr_out];
    else rd = erased[addr_out[19:16]] ? 8'hff : addr_out[7:0] ^ 8'h5a;
  end
  always @(posedge output_gate_n) last = rd;
  // Undriven lines flip so stale data never matches
  assign data_in = (!chip_select_n && !output_gate_n && powerdown_reset_n) ? rd : ~last;
  // Capture on whichever strobe rises first
  always @(posedge write_strobe_n or posedge chip_select_n) begin
    if (powerdown_reset_n && !(chip_select_n && write_strobe_n)) begin
      if (pend != 8'h0 && ready_busy_n) begin
        // Alteration only with supply up and block free or overridden
        if (SUPPLY_OK && (!locked[addr_out[19:16]] || HIGH_RESET)) begin
          if (pend == 8'h20) erased[addr_out[19:16]] = 1'b1;
          if (pend == 8'h40) mem[addr_out] = data_out;
        end
        if (SUPPLY_OK && pend == 8'h60 && data_out == 8'h01) locked[addr_out[19:16]] = 1'b1;
        if (SUPPLY_OK && pend == 8'h60 && data_out == 8'hd0) locked = 16'h0;
        pend = 8'h0;
        mode = 2'd1;
        ready_busy_n = 1'b0;
        ready_busy_n <= #BUSY_NS 1'b1; // release outlasts an aborting reset
      end else if (data_out == 8'hff && ready_busy_n) mode = 2'd0;
      else if (data_out == 8'h70) mode = 2'd1;
      else if (data_out == 8'h90) mode = 2'd2;
      else pend = data_out;
    end
  end
  // Deep power-down clears command state
  always @(negedge powerdown_reset_n) begin
    mode = 2'd0;
    pend = 8'h0;
  end
endmodule // fbmc_flash_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, rst, req_valid, req_ready, rsp_valid, busy, chip_select_n, output_gate_n;
  logic write_strobe_n, powerdown_reset_n, data_oe_n, ready_busy_n;
  logic [2:0] req_op;
  logic [19:0] req_addr, addr_out;
  logic [7:0] req_data, rsp_data, data_out, data_in;
  int bad_count, tests_run, cycles;
  fbmc_host DUT (.ref_clk, .rst, .req_valid, .req_op, .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_data,
    .busy, .addr_out, .chip_select_n, .output_gate_n, .write_strobe_n, .powerdown_reset_n, .data_out, .data_oe_n,
    .data_in, .ready_busy_n);
  fbmc_flash_model u_flash (.addr_out, .chip_select_n, .output_gate_n, .write_strobe_n, .powerdown_reset_n,
    .data_out, .data_in, .ready_busy_n);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // One request, held until taken, then run to idle
  task automatic req(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d, output logic [7:0] got);
    @(posedge ref_clk);
    {req_valid, req_op, req_addr, req_data} <= {1'b1, op, a, d};
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      if (rsp_valid === 1'b1) got = rsp_data;
    end while (req_ready !== 1'b1);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d);
    logic [7:0] g;
    req(op, a, d, g);
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    logic [7:0] g;
    g = 8'hxx;
    req(3'h0, a, 8'h0, g);
    tests_run++;
    if (g !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t read %h got %h exp %h", $time, a, g, exp);
    end
  endtask
  task automatic t_boot;
    rd(20'h12345, 8'h1f);
    rd(20'hfffff, 8'ha5);
    $display("boot done");
  endtask
  task automatic t_write;
    cmd(3'h3, 20'h30001, 8'ha5);
    rd(20'h30001, 8'ha5);
    rd(20'h30002, 8'h58);
    $display("write done");
  endtask
  task automatic t_erase;
    cmd(3'h2, 20'hf1234, 8'h0);
    rd(20'hf0000, 8'hff);
    rd(20'hfffff, 8'hff);
    rd(20'heffff, 8'ha5);
    $display("erase done");
  endtask
  task automatic t_modes;
    cmd(3'h1, 20'h0, 8'h70);
    rd(20'h55555, 8'h80);
    cmd(3'h1, 20'h0, 8'h90);
    rd(20'h0, 8'h3c);
    rd(20'h1, 8'hc3);
    cmd(3'h1, 20'h0, 8'hff);
    rd(20'h00011, 8'h4b);
    $display("modes done");
  endtask
  task automatic t_lock;
    cmd(3'h4, 20'h20000, 8'h0);
    cmd(3'h5, 20'h0, 8'h0);
    cmd(3'h6, 20'h0, 8'h0);
    rd(20'h20003, 8'h59);
    $display("lock done");
  endtask
  task automatic t_reset;
    cmd(3'h1, 20'h0, 8'h70);
    cmd(3'h7, 20'h0, 8'h0);
    rd(20'h00020, 8'h7a);
    $display("reset done");
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      bad_count++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {rst, req_valid, req_op, req_addr, req_data} <= {1'b1, 1'b0, 3'h0, 20'h0, 8'h0};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_boot();
    t_write();
    t_erase();
    t_modes();
    t_lock();
    t_reset();
    complete_run();
  end
endmodule // tb
`default_nettype wire
